// file: testbench/gate_driver_selftest_control_tb.sv
// Testbench: controller-driver pair plus a bench-driven driver for direct register checks
`timescale 1ns/1ps
module gate_driver_selftest_control_tb;
   import gdst_pkg::*;
   logic ref_clk_i, sys_rst_i, active, cmd_valid, cmd_ready, done, host_pass, thr_b, clr_b;
   logic gate_a, gate_b, clr_a;
   logic [FLAG_W-1:0] ff_a, ff_b, trip_a;
   logic [3:0] cmd_bit;
   logic [FLAG_W-1:0] trip;
   logic [REG_W-1:0] cfg;
   logic [7:0] ck_b;
   int bad_count = 0;
   int tests_run = 0;
   int bt[9] = '{13, 12, 11, 9, 8, 7, 3, 2, 1};
   int fl[9] = '{0, 0, 1, 2, 3, 4, 5, 6, 7};
   int pv[9] = '{0, 1, 0, 1, 1, 1, 1, 1, 1};
   gdst_if lnk1();
   gdst_if lnk2();
   gdst_host #(.SETTLE_CYCLES(2), .WAIT_CYCLES(20)) u_gdst_host (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
      .link(lnk1), .active_state_i(active), .cmd_valid_i(cmd_valid), .cmd_bit_i(cmd_bit), .cmd_ready_o(cmd_ready),
      .done_o(done), .pass_o(host_pass));
   gdst_device #(.CLEAR_CYCLES(2)) u_gdst_device (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .link(lnk1),
      .comparator_trip_i(trip_a), .config_word_i(cfg), .high_side_gate_output_o(gate_a), .gate_threshold_start_o(),
      .status_clear_o(clr_a), .config_checksum_o(), .fault_flags_o(ff_a));
   // Second driver lets the bench break sequencing and poke registers directly
   gdst_device #(.CLEAR_CYCLES(2)) u_gdst_device_b (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .link(lnk2),
      .comparator_trip_i(trip), .config_word_i(cfg), .high_side_gate_output_o(gate_b), .gate_threshold_start_o(thr_b),
      .status_clear_o(clr_b), .config_checksum_o(ck_b), .fault_flags_o(ff_b));
   gdst_asserts #(.CLEAR_CYCLES(2)) u_gdst_asserts (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
      .reg_wr(lnk1.reg_wr), .reg_rd(lnk1.reg_rd), .reg_wdata(lnk1.reg_wdata), .reg_rdata(lnk1.reg_rdata),
      .reg_rvalid(lnk1.reg_rvalid), .pwm_on(lnk1.pwm_on), .checksum_disable(lnk1.checksum_disable),
      .fault_flags(lnk1.fault_flags), .high_side_gate_output(lnk1.high_side_gate_output));
   //////////////////////////////////////////////////
   initial begin
      ref_clk_i = 1'b0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end
   task automatic results();
      if (bad_count == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic tmo(input int n, input int lim);
      if (n > lim) begin
         bad_count++;
         results();
      end
   endtask : tmo
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask : cyc
   task automatic wr(input logic [15:0] d);
      cyc(1);
      lnk2.reg_wr = 1'b1;
      lnk2.reg_wdata = d;
      cyc(1);
      lnk2.reg_wr = 1'b0;
   endtask : wr
   task automatic rd(output logic [15:0] v);
      int n;
      cyc(1);
      lnk2.reg_rd = 1'b1;
      cyc(1);
      lnk2.reg_rd = 1'b0;
      n = 0;
      while (lnk2.reg_rvalid !== 1'b1) begin
         n++;
         tmo(n, 4);
         cyc(1);
      end
      v = lnk2.reg_rdata;
   endtask : rd
   task automatic see_high(input int sel, output logic s);
      s = 1'b0;
      repeat (4) begin
         if ((sel == 0 ? thr_b : clr_b) === 1'b1) s = 1'b1;
         cyc(1);
      end
   endtask : see_high
   task automatic run_cmd(input int b);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1) begin
         n++;
         tmo(n, 50);
         cyc(1);
      end
      cmd_bit = 4'(b);
      cmd_valid = 1'b1;
      cyc(1);
      cmd_valid = 1'b0;
      n = 0;
      while (done !== 1'b1) begin
         n++;
         tmo(n, 300);
         cyc(1);
      end
      chk({15'h0000, host_pass}, 16'h0001);
   endtask : run_cmd
   //////////////////////////////////////////////////
   initial begin
      logic [15:0] v;
      logic s;
      sys_rst_i = 1'b1;
      active = 1'b1;
      cmd_valid = 1'b0;
      cmd_bit = 4'h0;
      trip = 8'h00;
      trip_a = 8'h00;
      cfg = 16'hA5C3;
      lnk2.reg_wr = 1'b0;
      lnk2.reg_rd = 1'b0;
      lnk2.reg_wdata = 16'h0000;
      lnk2.pwm_on = 1'b0;
      lnk2.checksum_disable = 1'b1;
      cyc(3);
      sys_rst_i = 1'b0;
      rd(v);
      chk(v, CTRL_RESET);
      wr(16'h4451);
      rd(v);
      chk(v, 16'h4451);
      lnk2.pwm_on = 1'b1;
      cyc(4);
      chk({8'h00, lnk2.fault_flags}, {8'h00, FLAGS_RESET});
      chk({15'h0000, lnk2.high_side_gate_output}, 16'h0001);
      wr(16'hC451);
      rd(v);
      chk(v, 16'h4451);
      for (int i = 0; i < 9; i++) begin
         lnk2.pwm_on = (pv[i] != 0);
         cyc(3);
         wr(16'(1) << bt[i]);
         cyc(3);
         chk({8'h00, lnk2.fault_flags}, 16'(1) << fl[i]);
         chk({8'h00, ff_b}, 16'(1) << fl[i]);
         if (bt[i] >= 12) chk({15'h0000, lnk2.high_side_gate_output}, 16'h0000);
         if (bt[i] == 3) rd(v);
         if (bt[i] == 3) chk(v, 16'h0008);
         if (bt[i] == 2) chk({8'h00, ck_b}, {8'h00, cfg[15:8] ^ cfg[7:0]});
         wr(16'h0000);
         lnk2.pwm_on = 1'b1;
         cyc(3);
         if (bt[i] == 13) chk({15'h0000, lnk2.high_side_gate_output}, 16'h0000);
         wr(16'h8000);
         see_high(1, s);
         chk({15'h0000, s}, 16'h0001);
         cyc(4);
         chk({8'h00, lnk2.fault_flags}, 16'h0000);
         chk({14'h0000, clr_b, lnk2.high_side_gate_output}, 16'h0001);
         chk({15'h0000, gate_b}, 16'h0001);
      end
      wr(16'h0020);
      see_high(0, s);
      chk({15'h0000, s}, 16'h0001);
      // A genuine trip must stick after the source goes away
      trip = 8'h10;
      cyc(3);
      trip = 8'h00;
      cyc(3);
      chk({8'h00, lnk2.fault_flags}, 16'h0010);
      // A genuine trip on the paired driver must be wiped by the first sequenced clear
      trip_a = 8'h80;
      cyc(3);
      trip_a = 8'h00;
      cyc(3);
      chk({8'h00, ff_a}, 16'h0080);
      for (int i = 0; i < 9; i++) begin
         run_cmd(bt[i]);
         chk({15'h0000, lnk1.checksum_disable}, 16'h0000);
         chk({6'h00, gate_a, clr_a, ff_a}, 16'h0000);
      end
      active = 1'b0;
      cmd_valid = 1'b1;
      cyc(6);
      chk({14'h0000, cmd_ready, lnk1.checksum_disable}, 16'h0000);
      cmd_valid = 1'b0;
      results();
   end
endmodule : gate_driver_selftest_control_tb

// file: testbench/gdst_asserts.sv
// Checker: register, gate and self-test sequencing properties on the controller-driver link
`timescale 1ns/1ps
module gdst_asserts
   import gdst_pkg::*;
#(
   parameter int CLEAR_CYCLES = STATUS_CLEAR_CYCLES
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [REG_W-1:0] reg_wdata,
   input wire logic [REG_W-1:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic pwm_on,
   input wire logic checksum_disable,
   input wire logic [FLAG_W-1:0] fault_flags,
   input wire logic high_side_gate_output
);
   logic [REG_W-1:0] sh_q;
   logic hold_q;
   logic [7:0] clr_q;
   logic [FLAG_W-1:0] fm;
   // Flags each written test bit must force, in flag-vector order
   assign fm = {reg_wdata[1], reg_wdata[2], reg_wdata[3], reg_wdata[7], reg_wdata[8], reg_wdata[9], reg_wdata[11],
                (reg_wdata[13] & !pwm_on) | (reg_wdata[12] & pwm_on)};
   //////////////////////////////////////////////////
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sh_q <= CTRL_RESET;
      end else if (reg_wr) begin
         sh_q <= reg_wdata;
      end
   end
   // Sets with the driver's hold but releases a cycle after it, so it only ever widens the hold window
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         hold_q <= 1'b0;
      end else if (sh_q[13]) begin
         hold_q <= 1'b1;
      end else if (!fault_flags[0]) begin
         hold_q <= 1'b0;
      end
   end
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         clr_q <= 8'h00;
      end else if (reg_wr && reg_wdata[15]) begin
         clr_q <= 8'(CLEAR_CYCLES + 4);
      end else if (clr_q != 8'h00) begin
         clr_q <= clr_q - 8'h01;
      end
   end
   //////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   AST_READ: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered");
   AST_B15_ZERO: assert property (reg_rvalid |-> !reg_rdata[15])
      else $error("status clear bit read as one");
   AST_CLR_ONLY: assert property (|($past(fault_flags) & ~fault_flags) |-> clr_q != 8'h00)
      else $error("flag dropped without status clear");
   AST_CLR_DONE: assert property (reg_wr && reg_wdata == 16'h8000 |-> ##[3:8] fault_flags == 8'h00)
      else $error("status clear left flags set");
   AST_GATE_HELD: assert property ((sh_q[13] | sh_q[12]) && $past(sh_q[13] | sh_q[12]) |-> !high_side_gate_output)
      else $error("gate high during gate check");
   AST_OFF_HOLD: assert property (hold_q && $past(hold_q) && $past(hold_q, 2) |-> !high_side_gate_output)
      else $error("gate released before flag and bit cleared");
   AST_FORCE: assert property (reg_wr |-> ##3 (fault_flags & $past(fm, 3)) == $past(fm, 3))
      else $error("self test did not set its flag");
   AST_CKDIS: assert property (reg_wr && (reg_wdata & 16'h3B82) != 16'h0000 |-> checksum_disable)
      else $error("test requested with checksum enabled");
   AST_PWM_OFF: assert property (reg_wr && (reg_wdata[13] || reg_wdata[11]) |-> !pwm_on)
      else $error("off-type test requested with pwm on");
   AST_PWM_ON: assert property (reg_wr && (reg_wdata & 16'h1382) != 16'h0000 |-> pwm_on)
      else $error("on-type test requested with pwm off");
   AST_CKEND: assert property ($rose(checksum_disable) |-> ##[1:600] !checksum_disable)
      else $error("checksum left disabled");
endmodule : gdst_asserts

// file: verilog/gdst_device.sv
// Driver end: secondary self-test control register, forced comparator faults and gate output gating
`timescale 1ns/1ps
module gdst_device
   import gdst_pkg::*;
#(
   parameter int CLEAR_CYCLES = STATUS_CLEAR_CYCLES,
   parameter bit HAS_THRESHOLD = 1'b1
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   gdst_if.driver link,
   input wire logic [FLAG_W-1:0] comparator_trip_i,
   input wire logic [REG_W-1:0] config_word_i,
   output logic high_side_gate_output_o,
   output logic gate_threshold_start_o,
   output logic status_clear_o,
   output logic [7:0] config_checksum_o,
   output logic [FLAG_W-1:0] fault_flags_o
);

   generate
      if (CLEAR_CYCLES < 1 || CLEAR_CYCLES > 255) begin : g_bad_clear
         $error("CLEAR_CYCLES must lie in 1..255");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Control register

   logic [REG_W-1:0] ctrl_q;
   logic [7:0] clear_cnt_q;
   logic clear_busy;

   assign clear_busy = (clear_cnt_q != 8'h00);

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl_q <= CTRL_RESET;
      end else begin
         if (link.reg_wr) begin
            ctrl_q <= link.reg_wdata;
         end else if (clear_cnt_q == 8'h01) begin
            ctrl_q[BIT_STATUS_CLEAR] <= 1'b0;
         end
      end
   end

   // A write that sets the bit again while clearing restarts the count
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         clear_cnt_q <= 8'h00;
      end else begin
         if (link.reg_wr && link.reg_wdata[BIT_STATUS_CLEAR]) begin
            clear_cnt_q <= 8'(CLEAR_CYCLES);
         end else if (link.reg_wr && !link.reg_wdata[BIT_STATUS_CLEAR]) begin
            clear_cnt_q <= 8'h00;
         end else if (clear_busy) begin
            clear_cnt_q <= clear_cnt_q - 8'h01;
         end
      end
   end

   // Reads are served from plain flops with no dependence on the clock monitor test
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         link.reg_rdata <= 16'h0000;
         link.reg_rvalid <= 1'b0;
      end else begin
         link.reg_rvalid <= link.reg_rd;
         if (link.reg_rd) begin
            link.reg_rdata <= ctrl_q & ~(16'h0001 << BIT_STATUS_CLEAR);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Forced comparator faults and sticky flags

   logic [FLAG_W-1:0] flags_q;
   logic [FLAG_W-1:0] flag_set;

   // Reserved control bits feed nothing here
   always_comb begin
      flag_set = comparator_trip_i;
      flag_set[FLG_GATE_MON] = comparator_trip_i[FLG_GATE_MON]
         | (ctrl_q[BIT_GATE_OFF] & ~link.pwm_on)
         | (ctrl_q[BIT_GATE_ON] & link.pwm_on);
      flag_set[FLG_COLLECTOR_OV] = comparator_trip_i[FLG_COLLECTOR_OV] | ctrl_q[BIT_CLAMP];
      flag_set[FLG_SATURATION] = comparator_trip_i[FLG_SATURATION] | ctrl_q[BIT_SATURATION];
      flag_set[FLG_SHORT] = comparator_trip_i[FLG_SHORT] | ctrl_q[BIT_SHORT];
      flag_set[FLG_OVERCURRENT] = comparator_trip_i[FLG_OVERCURRENT] | ctrl_q[BIT_OVERCURRENT];
      flag_set[FLG_CLOCK] = comparator_trip_i[FLG_CLOCK] | ctrl_q[BIT_CLOCK_MON];
      flag_set[FLG_CHECKSUM] = comparator_trip_i[FLG_CHECKSUM] | ctrl_q[BIT_CHECKSUM];
      flag_set[FLG_OVERTEMP] = comparator_trip_i[FLG_OVERTEMP] | ctrl_q[BIT_OVERTEMP];
   end

   // A fault still present in the last cycle of the status clear is kept
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         flags_q <= FLAGS_RESET;
      end else begin
         flags_q <= (flags_q & ~{FLAG_W{clear_busy}}) | flag_set;
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         link.fault_flags <= FLAGS_RESET;
         fault_flags_o <= FLAGS_RESET;
         status_clear_o <= 1'b0;
      end else begin
         link.fault_flags <= flags_q;
         fault_flags_o <= flags_q;
         status_clear_o <= clear_busy;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Gate output

   logic off_hold_q;
   logic gate_d;

   // The hold only drops once both the request bit and the monitor flag are gone
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         off_hold_q <= 1'b0;
      end else begin
         if (ctrl_q[BIT_GATE_OFF]) begin
            off_hold_q <= 1'b1;
         end else if (!flags_q[FLG_GATE_MON]) begin
            off_hold_q <= 1'b0;
         end
      end
   end

   assign gate_d = link.pwm_on & ~off_hold_q & ~ctrl_q[BIT_GATE_OFF]
      & ~ctrl_q[BIT_GATE_ON];

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         high_side_gate_output_o <= 1'b0;
         link.high_side_gate_output <= 1'b0;
      end else begin
         high_side_gate_output_o <= gate_d;
         link.high_side_gate_output <= gate_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Threshold measurement start and configuration checksum

   logic thr_prev_q;
   logic chk_prev_q;
   logic [7:0] sum_d;

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         thr_prev_q <= 1'b0;
         gate_threshold_start_o <= 1'b0;
      end else begin
         thr_prev_q <= ctrl_q[BIT_THRESHOLD];
         gate_threshold_start_o <= HAS_THRESHOLD & ctrl_q[BIT_THRESHOLD] & ~thr_prev_q;
      end
   end

   // Folded byte XOR of the configuration word; cheap, and only the forced fault is checked by software
   always_comb begin
      sum_d = config_word_i[7:0] ^ config_word_i[15:8];
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         chk_prev_q <= 1'b0;
         config_checksum_o <= 8'h00;
      end else begin
         chk_prev_q <= ctrl_q[BIT_CHECKSUM];
         if (ctrl_q[BIT_CHECKSUM] && !chk_prev_q) begin
            config_checksum_o <= sum_d;
         end
      end
   end

endmodule : gdst_device

// file: verilog/gdst_host.sv
// Controller end: runs one self-test at a time with PWM set up and checksum disabled around it
`timescale 1ns/1ps
module gdst_host
   import gdst_pkg::*;
#(
   parameter int SETTLE_CYCLES = PWM_SETTLE_CYCLES,
   parameter int WAIT_CYCLES = FAULT_WAIT_CYCLES
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   gdst_if.controller link,
   input wire logic active_state_i,
   input wire logic cmd_valid_i,
   input wire logic [3:0] cmd_bit_i,
   output logic cmd_ready_o,
   output logic done_o,
   output logic pass_o
);

   generate
      if (SETTLE_CYCLES < 1 || WAIT_CYCLES < 1 || SETTLE_CYCLES > 65535 || WAIT_CYCLES > 65535) begin : g_bad
         $error("SETTLE_CYCLES and WAIT_CYCLES must lie in 1..65535");
      end
   endgenerate

   typedef enum logic [6:0] {
      H_IDLE = 7'h01,
      H_PREP = 7'h02,
      H_ARM = 7'h04,
      H_WAIT = 7'h08,
      H_DROP = 7'h10,
      H_CLEAR = 7'h20,
      H_END = 7'h40
   } gdst_hstate_e;

   gdst_hstate_e state_q;
   logic [3:0] bit_q;
   logic [15:0] cnt_q;
   logic seen_q;
   logic want_on;
   logic [2:0] flag_idx;

   // Off-state checks need the output off, all others need it on
   assign want_on = !(bit_q == 4'(BIT_GATE_OFF) || bit_q == 4'(BIT_CLAMP));

   always_comb begin
      case (bit_q)
         4'(BIT_GATE_OFF), 4'(BIT_GATE_ON): flag_idx = 3'(FLG_GATE_MON);
         4'(BIT_CLAMP): flag_idx = 3'(FLG_COLLECTOR_OV);
         4'(BIT_SATURATION): flag_idx = 3'(FLG_SATURATION);
         4'(BIT_SHORT): flag_idx = 3'(FLG_SHORT);
         4'(BIT_OVERCURRENT): flag_idx = 3'(FLG_OVERCURRENT);
         4'(BIT_CLOCK_MON): flag_idx = 3'(FLG_CLOCK);
         4'(BIT_CHECKSUM): flag_idx = 3'(FLG_CHECKSUM);
         default: flag_idx = 3'(FLG_OVERTEMP);
      endcase
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_q <= H_IDLE;
         bit_q <= 4'h0;
         cnt_q <= 16'h0000;
         seen_q <= 1'b0;
         link.reg_wr <= 1'b0;
         link.reg_rd <= 1'b0;
         link.reg_wdata <= 16'h0000;
         link.pwm_on <= 1'b0;
         link.checksum_disable <= 1'b0;
         cmd_ready_o <= 1'b0;
         done_o <= 1'b0;
         pass_o <= 1'b0;
      end else begin
         link.reg_wr <= 1'b0;
         link.reg_rd <= 1'b0;
         done_o <= 1'b0;
         case (state_q)
            H_IDLE: begin
               cmd_ready_o <= active_state_i;
               // Commands outside the active state are ignored
               if (cmd_valid_i && cmd_ready_o && active_state_i) begin
                  bit_q <= cmd_bit_i;
                  cmd_ready_o <= 1'b0;
                  link.checksum_disable <= 1'b1;
                  cnt_q <= 16'(SETTLE_CYCLES);
                  seen_q <= 1'b0;
                  state_q <= H_PREP;
               end
            end
            H_PREP: begin
               link.pwm_on <= want_on;
               if (cnt_q == 16'h0001) begin
                  state_q <= H_ARM;
               end
               cnt_q <= cnt_q - 16'h0001;
            end
            H_ARM: begin
               link.reg_wr <= 1'b1;
               link.reg_wdata <= 16'h0001 << bit_q;
               cnt_q <= 16'(WAIT_CYCLES);
               state_q <= H_WAIT;
            end
            H_WAIT: begin
               if (link.fault_flags[flag_idx] || cnt_q == 16'h0001) begin
                  seen_q <= link.fault_flags[flag_idx];
                  link.reg_wr <= 1'b1;
                  link.reg_wdata <= 16'h0000;
                  link.pwm_on <= 1'b0;
                  state_q <= H_DROP;
               end
               cnt_q <= cnt_q - 16'h0001;
            end
            H_DROP: begin
               link.reg_wr <= 1'b1;
               link.reg_wdata <= 16'h0001 << BIT_STATUS_CLEAR;
               cnt_q <= 16'(STATUS_CLEAR_CYCLES + 2);
               state_q <= H_CLEAR;
            end
            H_CLEAR: begin
               if (cnt_q == 16'h0001) begin
                  state_q <= H_END;
               end
               cnt_q <= cnt_q - 16'h0001;
            end
            H_END: begin
               link.checksum_disable <= 1'b0;
               link.reg_rd <= 1'b1;
               done_o <= 1'b1;
               pass_o <= seen_q;
               state_q <= H_IDLE;
            end
            default: begin
               state_q <= H_IDLE;
            end
         endcase
      end
   end

endmodule : gdst_host

// file: verilog/gdst_if.sv
// Interface: register strobes, PWM input, checksum disable and fault flags between controller and driver
`timescale 1ns/1ps
interface gdst_if;
   import gdst_pkg::*;

   logic reg_wr;
   logic reg_rd;
   logic [REG_W-1:0] reg_wdata;
   logic [REG_W-1:0] reg_rdata;
   logic reg_rvalid;
   logic pwm_on;
   logic checksum_disable;
   logic [FLAG_W-1:0] fault_flags;
   logic high_side_gate_output;

   modport driver (
      input reg_wr, reg_rd, reg_wdata, pwm_on, checksum_disable,
      output reg_rdata, reg_rvalid, fault_flags, high_side_gate_output
   );
   modport controller (
      output reg_wr, reg_rd, reg_wdata, pwm_on, checksum_disable,
      input reg_rdata, reg_rvalid, fault_flags, high_side_gate_output
   );
endinterface : gdst_if

// file: verilog/gdst_pkg.sv
// Package: register layout, fault flag positions and timing for the gate driver self-test control
package gdst_pkg;

   localparam int REG_W = 16;
   localparam int FLAG_W = 8;

   // Control register field positions
   localparam int BIT_STATUS_CLEAR = 15;
   localparam int BIT_GATE_OFF = 13;
   localparam int BIT_GATE_ON = 12;
   localparam int BIT_CLAMP = 11;
   localparam int BIT_SATURATION = 9;
   localparam int BIT_SHORT = 8;
   localparam int BIT_OVERCURRENT = 7;
   localparam int BIT_THRESHOLD = 5;
   localparam int BIT_CLOCK_MON = 3;
   localparam int BIT_CHECKSUM = 2;
   localparam int BIT_OVERTEMP = 1;
   localparam logic [REG_W-1:0] CTRL_RESET = 16'h0000;

   // Fault flag positions on the flag vector
   localparam int FLG_GATE_MON = 0;
   localparam int FLG_COLLECTOR_OV = 1;
   localparam int FLG_SATURATION = 2;
   localparam int FLG_SHORT = 3;
   localparam int FLG_OVERCURRENT = 4;
   localparam int FLG_CLOCK = 5;
   localparam int FLG_CHECKSUM = 6;
   localparam int FLG_OVERTEMP = 7;
   localparam logic [FLAG_W-1:0] FLAGS_RESET = 8'h00;

   // Timing
   localparam int CLK_PERIOD_PS = 5000;
   localparam int STATUS_CLEAR_NS = 20;
   localparam int STATUS_CLEAR_CYCLES = (STATUS_CLEAR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int PWM_SETTLE_NS = 100;
   localparam int PWM_SETTLE_CYCLES = (PWM_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int FAULT_WAIT_NS = 2000;
   localparam int FAULT_WAIT_CYCLES = (FAULT_WAIT_NS * 1000) / CLK_PERIOD_PS;

endpackage : gdst_pkg
